// [hw/scrs_pkg.sv]
package scrs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RESET_MAX_US = 12000; // Reset hold-off, 12 ms
	// Longest time, so round down
	localparam int unsigned RESET_CYC = RESET_MAX_US * (CLK_HZ / 1_000_000);

	////////////////////////////////////////////////////////////////////////////
	// Addresses and command codes
	localparam logic [6:0] DEF_ADDR = 7'h29;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [15:0] CMD_SLEEP = 16'h3677;
	localparam logic [15:0] CMD_ID_PREP = 16'h367c;
	localparam logic [15:0] CMD_ID_READ = 16'he102;

	////////////////////////////////////////////////////////////////////////////
	// Checksum
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_XOROUT = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Word encodings and identity
	localparam logic [15:0] CONC_ZERO = 16'h4000; // Word meaning 0 vol%
	localparam int unsigned CONC_FULL_LOG2 = 15; // 2^15 counts span 100 vol%
	localparam int unsigned TEMP_LSB_PER_DEGC = 200;
	localparam logic [23:0] PROD_CODE = 24'h5a_a501; // Arbitrary value
	localparam logic [7:0] PROD_REV = 8'h01; // Arbitrary value
	localparam logic [63:0] SERIAL_DEF = 64'h0123_4567_89ab_cdef; // Arbitrary value
	localparam logic [2:0] ID_WORDS = 3'h6;
	localparam logic [2:0] MEAS_WORDS = 3'h3;
	localparam logic [15:0] RSVD_WORD = 16'h0000;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_WR, L_WACK, L_RD, L_RACK} scrs_lst_t;

	typedef struct packed {
		logic [15:0] conc; // Unsigned, offset by CONC_ZERO
		logic signed [15:0] temp; // Two's complement, 1/200 degC
	} scrs_meas_t;

	typedef struct packed {
		logic [15:0] code;
		logic [15:0] arg;
	} scrs_cmd_t;

	typedef struct packed {
		logic sleep;
		logic busy;
		logic id_mode;
	} scrs_lvl_t;

	typedef struct packed {
		logic cmd;
		logic arg;
		logic gc;
		logic wake;
	} scrs_evt_t;

endpackage

// [hw/scrs_sync2.sv]
module scrs_sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic clk, // System clock
	input wire logic rst_b, // Synchronous reset
	input wire logic en, // Clock enable
	input wire logic [W-1:0] d, // Foreign level
	output logic [W-1:0] q // Synchronised level
);
	logic [W-1:0] m_r;
	logic [W-1:0] s_r;

	generate
		if (W < 1) begin : g_bad
			$error("scrs_sync2 width must be at least one");
		end
	endgenerate

	// Two stages; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			m_r <= '0;
			s_r <= '0;
		end else if (en) begin
			m_r <= d;
			s_r <= m_r;
		end
	end

	assign q = s_r;
endmodule // scrs_sync2

// [hw/scrs_crc8.sv]
module scrs_crc8 (
	input wire logic [7:0] crc_in, // Running checksum
	input wire logic [7:0] data, // Next byte, msb first
	output logic [7:0] crc_out // Updated checksum
);
	import scrs_pkg::*;

	logic [7:0] c;

	// Bitwise polynomial division, no reflection
	always_comb begin
		c = crc_in ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		crc_out = c;
	end
endmodule // scrs_crc8

// [hw/scrs_top.sv]
// Operation
// - General call address, write, then byte 0x06 starts a soft reset.
// - For up to 12 ms after reset start, no address ACK, no commands.
// - Sleep is entered only when no measurement runs; otherwise ignored.
// - While asleep the general call reset is ignored.
// - Own address with write bit wakes from sleep; that byte is not ACKed.
// - Identity read returns 32-bit product then 64-bit serial, msb first.
// - Low byte of the product word is the revision number.
// - Checksum: CRC-8, poly 0x31, init 0xFF, no reflection, xor 0x00.
// - One checksum byte follows each 16-bit read word.
// - Concentration word is unsigned, zero at 2^14, 2^15 counts per 100%.
// - Temperature words are signed 16-bit in 1/200 degC steps.
// - A bad checksum on a written argument is NACKed, action dropped.
module scrs_top #(
	parameter logic [6:0] DEV_ADDR = scrs_pkg::DEF_ADDR, // Own target address
	parameter int unsigned RESET_CYC = scrs_pkg::RESET_CYC, // Reset hold-off
	parameter logic [63:0] SERIAL = scrs_pkg::SERIAL_DEF // Serial number
) (
	input wire logic clk, // System clock, 40 MHz
	input wire logic rst_b, // Reset, active low
	input wire logic ce, // Clock enable for clk domain
	input wire logic scl, // Link clock from host
	input wire logic sda, // Data line level
	output logic sda_pull, // Data drive value, always low
	output logic sda_oe, // Data pull-down enable
	input wire logic meas_busy, // Measurement running
	input wire logic meas_stb, // New result on meas_res
	input wire scrs_pkg::scrs_meas_t meas_res, // Measurement result
	output logic sleep, // Sleep state
	output logic rst_busy, // Soft reset in progress
	output logic cfg_restore, // Pulse: restore defaults
	output logic cmd_stb, // Pulse: command for other logic
	output logic arg_stb, // Pulse: checked argument received
	output scrs_pkg::scrs_cmd_t cmd // Command code and argument
);
	import scrs_pkg::*;

	localparam int unsigned RCW = $clog2(RESET_CYC + 1);
	localparam logic [RCW-1:0] RC_LAST = RCW'(RESET_CYC - 1);

	generate
		if (RESET_CYC < 1) begin : g_bad
			$error("RESET_CYC must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Link domain state
	scrs_lst_t st_r;
	logic [2:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [2:0] wr_idx_r;
	logic [2:0] rd_word_r;
	logic [1:0] rd_pos_r;
	logic gc_r;
	logic drv_r;
	logic oe_r;
	logic pull_r;
	logic [7:0] crc_r;
	logic [7:0] crc_nxt;
	scrs_cmd_t cmdw_r;
	scrs_evt_t tgl_r;
	logic st_tgl_r;
	logic st_seen_r;
	scrs_lvl_t lvl_m_r;
	scrs_lvl_t lvl_s_r;

	// Clk domain state
	logic busy_r;
	logic [RCW-1:0] rcnt_r;
	logic restore_r;
	logic sleep_r;
	logic id_r;
	logic armed_r;
	logic cmd_stb_r;
	logic arg_stb_r;
	scrs_cmd_t cmd_r;
	scrs_meas_t snap_r;
	scrs_evt_t evt_s;
	scrs_evt_t evt_d_r;
	scrs_lvl_t lvl_c;

	////////////////////////////////////////////////////////////////////////////
	// Start marker: SDA falls while SCL is high
	always_ff @(negedge sda or negedge rst_b) begin
		if (!rst_b) begin
			st_tgl_r <= 1'b0;
		end else if (scl) begin
			st_tgl_r <= ~st_tgl_r;
		end
	end

	// Link decode; the marker settles half a period before the next rise
	wire start_now = st_tgl_r ^ st_seen_r;
	wire [7:0] rx_byte = {sh_r[6:0], sda};
	wire byte_end = cnt_r == 3'h7;
	wire addr_wr = !rx_byte[0];
	wire addr_own = rx_byte[7:1] == DEV_ADDR;
	wire addr_gc = rx_byte[7:1] == GC_ADDR && addr_wr;
	wire wake_hit = addr_own && addr_wr && lvl_s_r.sleep;
	// Busy or asleep: silence, general call included
	wire addr_ack = !lvl_s_r.busy && !lvl_s_r.sleep && (addr_own || addr_gc);
	wire gc_rst_hit = gc_r && wr_idx_r == 3'h0 && rx_byte == GC_RESET;
	wire crc_ok = (crc_r ^ CRC_XOROUT) == rx_byte;
	wire wr_ack = gc_r ? gc_rst_hit : (wr_idx_r < 3'h4 || (wr_idx_r == 3'h4 && crc_ok));
	wire wr_last = wr_idx_r == 3'h5;

	// Read source; words are quasi-static while a frame runs
	wire [95:0] rd_vec = lvl_s_r.id_mode ? {PROD_CODE, PROD_REV, SERIAL}
		: {snap_r.conc, snap_r.temp, RSVD_WORD, 48'h0};
	wire [2:0] n_words = lvl_s_r.id_mode ? ID_WORDS : MEAS_WORDS;
	wire [95:0] rd_shift = rd_vec << {rd_word_r, 4'h0};
	wire [15:0] rd_word = rd_shift[95:80];
	wire rd_past = rd_word_r >= n_words;
	wire [7:0] next_byte = rd_past ? IDLE_BYTE
		: rd_pos_r == 2'h0 ? rd_word[15:8]
		: rd_pos_r == 2'h1 ? rd_word[7:0]
		: crc_r ^ CRC_XOROUT;
	wire do_load = st_r == L_AACK || (st_r == L_RACK && !sda);
	wire in_wr = st_r == L_WR;
	wire [7:0] crc_dat = in_wr ? rx_byte : next_byte;
	wire crc_fresh = in_wr ? wr_idx_r == 3'h2 : rd_pos_r == 2'h0;
	wire [7:0] crc_seed = crc_fresh ? CRC_INIT : crc_r;
	wire crc_upd = (in_wr && byte_end && (wr_idx_r == 3'h2 || wr_idx_r == 3'h3))
		|| (do_load && rd_pos_r != 2'h2 && !rd_past);

	scrs_crc8 u_crc (
		.crc_in(crc_seed),
		.data(crc_dat),
		.crc_out(crc_nxt)
	);

	////////////////////////////////////////////////////////////////////////////
	// Link sequencer; each start begins a fresh frame
	always_ff @(posedge scl or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= L_IDLE;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			tx_r <= 8'hff;
			wr_idx_r <= 3'h0;
			rd_word_r <= 3'h0;
			rd_pos_r <= 2'h0;
			gc_r <= 1'b0;
			drv_r <= 1'b0;
			crc_r <= CRC_INIT;
			cmdw_r <= '0;
			tgl_r <= '0;
			st_seen_r <= 1'b0;
		end else begin
			st_seen_r <= st_tgl_r;
			sh_r <= rx_byte;
			cnt_r <= cnt_r + 3'h1;
			if (crc_upd) begin
				crc_r <= crc_nxt;
			end
			if (start_now) begin
				st_r <= L_ADDR;
				cnt_r <= 3'h1;
				drv_r <= 1'b0;
				wr_idx_r <= 3'h0;
				rd_word_r <= 3'h0;
				rd_pos_r <= 2'h0;
			end else begin
				case (st_r)
					L_ADDR: begin
						if (byte_end) begin
							gc_r <= addr_gc;
							drv_r <= addr_ack;
							st_r <= !addr_ack ? L_IDLE : addr_wr ? L_WACK : L_AACK;
							tgl_r.wake <= tgl_r.wake ^ wake_hit;
						end
					end
					L_WR: begin
						if (byte_end) begin
							drv_r <= wr_ack;
							st_r <= L_WACK;
							wr_idx_r <= wr_idx_r + {2'h0, !wr_last};
							tgl_r.gc <= tgl_r.gc ^ gc_rst_hit;
							if (!gc_r) begin
								case (wr_idx_r)
									3'h0: cmdw_r.code[15:8] <= rx_byte;
									3'h1: cmdw_r.code[7:0] <= rx_byte;
									3'h2: cmdw_r.arg[15:8] <= rx_byte;
									3'h3: cmdw_r.arg[7:0] <= rx_byte;
									default: cmdw_r <= cmdw_r;
								endcase
								tgl_r.cmd <= tgl_r.cmd ^ (wr_idx_r == 3'h1);
								tgl_r.arg <= tgl_r.arg ^ (wr_idx_r == 3'h4 && crc_ok);
							end
						end
					end
					L_WACK: begin
						drv_r <= 1'b0;
						cnt_r <= 3'h0;
						st_r <= L_WR;
					end
					L_AACK, L_RACK: begin
						if (do_load) begin
							tx_r <= next_byte;
							drv_r <= !next_byte[7];
							cnt_r <= 3'h0;
							st_r <= L_RD;
							rd_pos_r <= rd_pos_r == 2'h2 ? 2'h0 : rd_pos_r + 2'h1;
							if (rd_pos_r == 2'h2 && rd_word_r != 3'h7) begin
								rd_word_r <= rd_word_r + 3'h1;
							end
						end else begin
							drv_r <= 1'b0;
							st_r <= L_IDLE;
						end
					end
					L_RD: begin
						tx_r <= {tx_r[6:0], 1'b1};
						drv_r <= !byte_end && !tx_r[6];
						if (byte_end) begin
							st_r <= L_RACK;
						end
					end
					L_IDLE: drv_r <= 1'b0;
					default: st_r <= L_IDLE;
				endcase
			end
		end
	end

	// Pin drive changes only while SCL is low
	always_ff @(negedge scl or negedge rst_b) begin
		if (!rst_b) begin
			oe_r <= 1'b0;
			pull_r <= 1'b0;
		end else begin
			oe_r <= drv_r;
			pull_r <= 1'b0;
		end
	end

	// Levels into the link domain; the link clock stops between frames,
	// so the first two edges of a frame carry the update
	always_ff @(posedge scl or negedge rst_b) begin
		if (!rst_b) begin
			lvl_m_r <= '0;
			lvl_s_r <= '0;
		end else begin
			lvl_m_r <= lvl_c;
			lvl_s_r <= lvl_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Events into the clk domain; data held by the link long after the toggle
	scrs_sync2 #(.W(4)) u_evt_sync (
		.clk(clk),
		.rst_b(rst_b),
		.en(ce),
		.d(tgl_r),
		.q(evt_s)
	);

	assign lvl_c = '{sleep: sleep_r, busy: busy_r, id_mode: id_r};
	wire scrs_evt_t evt_p = evt_s ^ evt_d_r;
	wire cmd_ev = evt_p.cmd;
	wire gc_ev = evt_p.gc;
	wire wake_ev = evt_p.wake;
	wire is_sleep = cmdw_r.code == CMD_SLEEP;
	wire is_prep = cmdw_r.code == CMD_ID_PREP;
	wire is_idrd = cmdw_r.code == CMD_ID_READ;
	wire rst_go = gc_ev && !sleep_r && !busy_r;
	wire rst_done = busy_r && rcnt_r == RC_LAST;
	// Sleep request during a measurement is dropped, not deferred
	wire sleep_go = cmd_ev && is_sleep && !meas_busy && !busy_r;
	wire sleep_nxt = !(wake_ev || rst_done) && (sleep_r || sleep_go);
	// Identity needs the preparing write just before the reading one
	wire id_nxt = !rst_done && (cmd_ev ? (is_idrd && armed_r) : id_r);
	wire armed_nxt = !rst_done && (cmd_ev ? is_prep : armed_r);
	wire cmd_fwd = cmd_ev && !is_sleep && !is_prep && !is_idrd;

	// Control state, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			evt_d_r <= '0;
			busy_r <= 1'b0;
			rcnt_r <= '0;
			restore_r <= 1'b0;
			sleep_r <= 1'b0;
			id_r <= 1'b0;
			armed_r <= 1'b0;
			cmd_stb_r <= 1'b0;
			arg_stb_r <= 1'b0;
			cmd_r <= '0;
			snap_r <= '0;
		end else if (ce) begin
			evt_d_r <= evt_s;
			busy_r <= rst_go || (busy_r && !rst_done);
			rcnt_r <= busy_r ? rcnt_r + 1'b1 : '0;
			restore_r <= rst_done;
			sleep_r <= sleep_nxt;
			id_r <= id_nxt;
			armed_r <= armed_nxt;
			cmd_stb_r <= cmd_fwd && !busy_r;
			arg_stb_r <= evt_p.arg && !busy_r;
			if (cmd_ev || evt_p.arg) begin
				cmd_r <= cmdw_r;
			end
			if (rst_done) begin
				snap_r <= '0;
			end else if (meas_stb) begin
				snap_r <= meas_res;
			end
		end
	end

	assign sda_pull = pull_r;
	assign sda_oe = oe_r;
	assign sleep = sleep_r;
	assign rst_busy = busy_r;
	assign cfg_restore = restore_r;
	assign cmd_stb = cmd_stb_r;
	assign arg_stb = arg_stb_r;
	assign cmd = cmd_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	gc_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && gc_ev && !sleep_r && !busy_r |=> busy_r && rcnt_r == '0)
		else $error("general call reset did not start");
	busy_nack_a: assert property (@(posedge scl) disable iff (!rst_b)
		st_r == L_ADDR && byte_end && !start_now && lvl_s_r.busy |=> !drv_r ##1 !oe_r)
		else $error("address acknowledged during reset");
	sleep_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cmd_ev && is_sleep && meas_busy && !sleep_r |=> !sleep_r)
		else $error("sleep entered during measurement");
	// General call is refused at the address, so no reset event can follow
	sleep_gc_a: assert property (@(posedge scl) disable iff (!rst_b)
		st_r == L_ADDR && byte_end && !start_now && addr_gc && lvl_s_r.sleep |=> !drv_r)
		else $error("general call acknowledged while asleep");
	wake_nack_a: assert property (@(posedge scl) disable iff (!rst_b)
		st_r == L_ADDR && byte_end && !start_now && wake_hit
		|=> !drv_r && tgl_r.wake != $past(tgl_r.wake))
		else $error("wake address acknowledged or lost");
	wake_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && wake_ev |=> !sleep_r)
		else $error("sleep not left on wake");
	id_order_a: assert property (@(posedge scl) disable iff (!rst_b)
		do_load && !start_now && lvl_s_r.id_mode && rd_word_r == 3'h0 && rd_pos_r == 2'h0
		|=> tx_r == PROD_CODE[23:16] && oe_r == !PROD_CODE[23])
		else $error("identity does not open with product msb");
	id_rev_a: assert property (@(posedge scl) disable iff (!rst_b)
		do_load && !start_now && lvl_s_r.id_mode && rd_word_r == 3'h1 && rd_pos_r == 2'h1
		|=> tx_r == PROD_REV)
		else $error("revision byte misplaced");
	crc_tx_a: assert property (@(posedge scl) disable iff (!rst_b)
		do_load && !start_now && rd_pos_r == 2'h2 && !rd_past
		|=> tx_r == ($past(crc_r) ^ CRC_XOROUT) ##1 st_r == L_RD)
		else $error("checksum byte not sent after word");
	crc_nack_a: assert property (@(posedge scl) disable iff (!rst_b)
		in_wr && byte_end && !start_now && !gc_r && wr_idx_r == 3'h4 && !crc_ok
		|=> !drv_r && tgl_r.arg == $past(tgl_r.arg))
		else $error("bad argument checksum accepted");
	restore_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && rst_done |=> !busy_r && restore_r && !sleep_r && !id_r)
		else $error("soft reset did not end in idle defaults");

	sleep_enter_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(sleep_r));
	wake_c: cover property (@(posedge clk) disable iff (!rst_b) ce && wake_ev);
	reset_done_c: cover property (@(posedge clk) disable iff (!rst_b) restore_r);
	id_read_c: cover property (@(posedge scl) disable iff (!rst_b)
		st_r == L_RD && lvl_s_r.id_mode && rd_word_r == 3'h6);
endmodule // scrs_top

// [bench/scrs_host.sv]
// Host-side initiator model: drives the link clock and pulls the data line low
module scrs_host (
	output logic scl, // Link clock, high while idle
	output logic sda_low, // High while the host pulls data low
	input wire logic sda // Resolved data line level
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////////////
	// Link clock stands still between frames, so both lines start released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start condition: data falls while the clock is high
	task automatic start();
		sda_low = 1'b1;
		#15 scl = 1'b0;
		#7;
	endtask

	// One bit: data set up mid-low, 15 ns high, 15 ns low
	task automatic bit_out(input logic b);
		sda_low = ~b;
		#8 scl = 1'b1;
		#15 scl = 1'b0;
		#7;
	endtask

	// Byte out msb first; the ninth clock samples the target's answer
	task automatic wr_byte(input logic [7:0] b, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		sda_low = 1'b0;
		#8 scl = 1'b1;
		nak = sda;
		#15 scl = 1'b0;
		#7;
	endtask

	// Byte in, sampled on the rising clock; released line reads as pulled up
	task automatic rd_byte(input logic nak, output logic [7:0] b);
		sda_low = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#8 scl = 1'b1;
			b[i] = sda;
			#15 scl = 1'b0;
			#7;
		end
		bit_out(nak);
	endtask

	// Stop condition, then both lines stay released
	task automatic stop();
		sda_low = 1'b1;
		#8 scl = 1'b1;
		#8 sda_low = 1'b0;
		#15;
	endtask
endmodule // scrs_host

// [bench/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import scrs_pkg::*;

	localparam int unsigned RST_CYC = 60;
	localparam logic [7:0] AW = {DEF_ADDR, 1'b0};
	// Clock opens high so reset falls before the first rising edge
	logic clk = 1'b1;
	logic rst_b = 1'b1;
	logic ce = 1'b1;
	logic scl, sda, sda_pull, sda_oe, host_low;
	logic meas_busy = 1'b0;
	logic meas_stb = 1'b0;
	scrs_meas_t meas_res = '0;
	logic sleep, rst_busy, cfg_restore, cmd_stb, arg_stb;
	scrs_cmd_t cmd;
	int checks = 0;
	int n_mismatch = 0;
	int busy_cnt = 0;
	int restore_cnt = 0;
	int cmd_cnt = 0;
	int arg_cnt = 0;

	////////////////////////////////////////////////////////////////////////////
	// Clock, open-drain line with pull-up, instances
	always #12.5 clk = ~clk;
	assign sda = ~(sda_oe & ~sda_pull) & ~host_low;

	scrs_top #(.RESET_CYC(RST_CYC)) scrs_top_i (.clk(clk), .rst_b(rst_b), .ce(ce), .scl(scl),
		.sda(sda), .sda_pull(sda_pull), .sda_oe(sda_oe), .meas_busy(meas_busy),
		.meas_stb(meas_stb), .meas_res(meas_res), .sleep(sleep), .rst_busy(rst_busy),
		.cfg_restore(cfg_restore), .cmd_stb(cmd_stb), .arg_stb(arg_stb), .cmd(cmd));
	scrs_host scrs_host_i (.scl(scl), .sda_low(host_low), .sda(sda));

	// Pulse and level counters; counting cycles also proves pulse width
	always @(posedge clk) begin
		busy_cnt <= busy_cnt + int'(rst_busy === 1'b1);
		restore_cnt <= restore_cnt + int'(cfg_restore === 1'b1);
		cmd_cnt <= cmd_cnt + int'(cmd_stb === 1'b1);
		arg_cnt <= arg_cnt + int'(arg_stb === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Bench's own checksum, worked bit by bit msb first
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction

	// Write frame; bit i of nak is the answer to byte i, stop after a refusal
	task automatic xfer(input logic [7:0] q[$], output logic [7:0] nak);
		logic a;
		nak = 8'h00;
		scrs_host_i.start();
		foreach (q[i]) begin
			scrs_host_i.wr_byte(q[i], a);
			nak[i] = a;
			if (a) break;
		end
		scrs_host_i.stop();
		repeat (10) @(negedge clk); // Frame spacing beyond the crossing delay
	endtask

	// Read frame of n bytes, host refuses the last one to end it
	task automatic rd(input int n, output logic [7:0] r[$]);
		logic [7:0] b;
		logic a;
		r = {};
		scrs_host_i.start();
		scrs_host_i.wr_byte(AW | 8'h01, a);
		check(a, 0);
		for (int i = 0; i < n; i++) begin
			scrs_host_i.rd_byte(i == n - 1, b);
			r.push_back(b);
		end
		scrs_host_i.stop();
		repeat (10) @(negedge clk);
	endtask

	// Word msb first, then its checksum
	task automatic chk_word(input logic [7:0] r[$], input int i, input logic [15:0] w);
		check({r[i], r[i+1]}, w);
		check(r[i+2], crc8(w));
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_cmd();
		logic [7:0] n;
		int c0;
		c0 = cmd_cnt;
		xfer('{AW, 8'h12, 8'h34}, n);
		check(n, 0);
		check(cmd_cnt - c0, 1);
		check(cmd.code, 16'h1234);
		check(sda_pull, 0);
		check(crc8(16'hbeef), 8'h92);
		done("cmd");
	endtask

	// Clock enable low holds the command in the crossing until it rises again
	task automatic t_freeze();
		logic [7:0] n;
		int c0;
		c0 = cmd_cnt;
		ce = 1'b0;
		xfer('{AW, 8'h12, 8'h35}, n);
		check(n, 0);
		check(cmd_cnt - c0, 0);
		ce = 1'b1;
		repeat (10) @(negedge clk);
		check(cmd_cnt - c0, 1);
		check(cmd.code, 16'h1235);
		done("freeze");
	endtask

	// Good then damaged checksum on a temperature argument of 12.5 degC
	task automatic t_arg();
		logic [7:0] n;
		int a0;
		a0 = arg_cnt;
		xfer('{AW, 8'h12, 8'h34, 8'h09, 8'hc4, crc8(16'h09c4)}, n);
		check(n, 0);
		check(arg_cnt - a0, 1);
		check(cmd.arg, 16'sd2500);
		xfer('{AW, 8'h12, 8'h34, 8'h09, 8'hc4, crc8(16'h09c4) ^ 8'h01}, n);
		check(n, 8'h20);
		check(arg_cnt - a0, 1);
		done("arg");
	endtask

	// Result 32000 counts and -12.5 degC read with checksums, then filler
	task automatic t_meas();
		logic [7:0] r[$];
		@(negedge clk);
		meas_res = '{conc: 16'd32000, temp: -16'sd2500};
		meas_stb = 1'b1;
		@(negedge clk);
		meas_stb = 1'b0;
		rd(10, r);
		chk_word(r, 0, 16'd32000);
		chk_word(r, 3, 16'hf63c);
		chk_word(r, 6, 16'h0000);
		check(r[9], 8'hff);
		done("meas");
	endtask

	task automatic t_id();
		logic [7:0] n;
		logic [7:0] r[$];
		xfer('{AW, 8'h36, 8'h7c}, n);
		xfer('{AW, 8'he1, 8'h02}, n);
		rd(18, r);
		chk_word(r, 0, PROD_CODE[23:8]);
		chk_word(r, 3, {PROD_CODE[7:0], PROD_REV});
		check(r[4], PROD_REV);
		for (int i = 0; i < 4; i++) begin
			chk_word(r, 6 + 3 * i, SERIAL_DEF[63 - 16 * i -: 16]);
		end
		done("id");
	endtask

	// Refused while measuring, taken when idle, reset ignored, woken by address
	task automatic t_sleep();
		logic [7:0] n;
		@(negedge clk);
		meas_busy = 1'b1;
		xfer('{AW, 8'h36, 8'h77}, n);
		check(sleep, 0);
		meas_busy = 1'b0;
		xfer('{AW, 8'h36, 8'h77}, n);
		check(sleep, 1);
		xfer('{8'h00, 8'h06}, n);
		check(n, 8'h01);
		check({sleep, rst_busy}, 2'b10);
		xfer('{AW}, n);
		check(n, 8'h01);
		check(sleep, 0);
		xfer('{AW}, n);
		check(n, 0);
		done("sleep");
	endtask

	task automatic t_reset();
		logic [7:0] n;
		logic [7:0] r[$];
		int b0, r0;
		b0 = busy_cnt;
		r0 = restore_cnt;
		xfer('{8'h00, 8'h06}, n);
		check(n, 0);
		check(rst_busy, 1);
		xfer('{AW}, n);
		check(n, 8'h01);
		for (int i = 0; i < 200 && rst_busy !== 1'b0; i++) @(negedge clk);
		repeat (3) @(negedge clk);
		check(busy_cnt - b0, RST_CYC);
		check(restore_cnt - r0, 1);
		xfer('{AW}, n);
		check(n, 0);
		rd(3, r);
		chk_word(r, 0, 16'h0000);
		done("reset");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Whole run needs well under 8000 cycles; twice that means a hang
	initial begin
		repeat (16000) @(posedge clk);
		n_mismatch++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end

	// Link side clears on a falling reset edge, so reset must really fall
	initial begin
		@(negedge clk);
		rst_b = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (5) @(negedge clk);
		t_cmd();
		t_freeze();
		t_arg();
		t_meas();
		t_id();
		t_sleep();
		t_reset();
		print_verdict();
	end
endmodule // tb
